// file: verilog/dpt_pkg.sv
package dpt_pkg;

  // ==========================================================
  // Geometry
  localparam int VAR_N = 8;
  localparam int SETS = 128;
  localparam int WAYS = 4;
  localparam int FIX_N = SETS * WAYS;
  localparam int PAIRED_VIRTUAL_TAG_LSB = 13;
  localparam int ODD_BIT = 12;
  localparam int MASK_W = 16;

  typedef logic [1:0] dpt_way_t;
  typedef logic [6:0] dpt_set_t;
  typedef logic [8:0] dpt_faddr_t;
  typedef logic [9:0] dpt_idx_t;
  typedef logic [2:0] dpt_vidx_t;
  typedef logic [18:0] dpt_paired_virtual_tag_t;
  typedef logic [15:0] dpt_mask_t;

  localparam dpt_idx_t FIX_BASE = 10'h008;
  localparam dpt_idx_t IDX_LIMIT = 10'h208;
  localparam dpt_mask_t FIX_MASK = 16'h0000;
  localparam dpt_vidx_t RAND_RESET = 3'h7;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_INDEX = 8'h00;
  localparam logic [7:0] OFF_RANDOM = 8'h04;
  localparam logic [7:0] OFF_LO0 = 8'h08;
  localparam logic [7:0] OFF_LO1 = 8'h0C;
  localparam logic [7:0] OFF_PMASK = 8'h10;
  localparam logic [7:0] OFF_WIRED = 8'h14;
  localparam logic [7:0] OFF_HI = 8'h18;
  localparam logic [7:0] OFF_CONFIG = 8'h1C;
  localparam logic [7:0] OFF_CONFIG1 = 8'h20;
  localparam logic [7:0] OFF_CONFIG_REG_FOUR = 8'h24;
  localparam logic [7:0] OFF_CMD = 8'h28;
  localparam logic [7:0] OFF_STAT = 8'h2C;
  localparam logic [7:0] OFF_IMASK = 8'h30;

  // ==========================================================
  // Fields and fixed values
  localparam int HI_HASHED_ENTRY_INVALIDATE_BIT = 10;
  localparam int IDX_FAIL_BIT = 31;
  localparam logic [2:0] MT_DUAL = 3'h4;
  localparam logic [5:0] VAR_SIZE_M1 = 6'h07;
  localparam logic [1:0] EXT_DEF = 2'h2;
  localparam logic [3:0] CFG4_SETS_LOG2 = 4'h7;
  localparam logic [3:0] CFG4_WAYS_LOG2 = 4'h2;
  localparam logic [3:0] CFG4_PAGE_LOG2 = 4'hC;
  localparam int ST_MC_SET = 0;
  localparam int ST_MC_DUP = 1;
  localparam int ST_MISS = 2;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_PROBE = 3'b001,
    CMD_READ = 3'b010,
    CMD_WIDX = 3'b011,
    CMD_WRAND = 3'b100
  } dpt_cmd_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [19:0] pfn;
    logic d;
    logic v;
  } dpt_half_t;

  typedef struct packed {
    dpt_paired_virtual_tag_t paired_virtual_tag;
    dpt_mask_t mask;
    logic hashed_entry_invalidate;
    dpt_half_t lo0;
    dpt_half_t lo1;
  } dpt_entry_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } dpt_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] va;
  } dpt_tr_req_t;

  typedef struct packed {
    logic hit;
    logic miss;
    logic [19:0] pfn;
    logic v;
    logic d;
  } dpt_tr_resp_t;

  typedef struct packed {
    logic hit;
    dpt_idx_t idx;
    dpt_half_t half;
  } dpt_look_t;

endpackage

// file: verilog/dpt_dual_tlb.sv
`timescale 1ns/1ps
module dpt_dual_tlb (
  input wire logic clk_sys,
  input wire logic rst,
  input wire dpt_pkg::dpt_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire dpt_pkg::dpt_tr_req_t tr_req,
  output dpt_pkg::dpt_tr_resp_t tr_resp,
  output logic irq
);

  // ==========================================================
  // Storage
  dpt_pkg::dpt_entry_t var_mem [dpt_pkg::VAR_N];
  dpt_pkg::dpt_entry_t fix_mem [dpt_pkg::FIX_N];

  logic [31:0] index_reg;
  dpt_pkg::dpt_vidx_t random_reg;
  dpt_pkg::dpt_vidx_t wired_reg;
  dpt_pkg::dpt_paired_virtual_tag_t hi_paired_virtual_tag_reg;
  logic hi_hashed_entry_invalidate_reg;
  dpt_pkg::dpt_half_t lo0_reg;
  dpt_pkg::dpt_half_t lo1_reg;
  dpt_pkg::dpt_mask_t pmask_reg;
  dpt_pkg::dpt_way_t way_reg;
  logic [2:0] stat_reg;
  logic [2:0] stat_next;
  logic [2:0] imask_reg;

  // ==========================================================
  // Search of both arrays
  function automatic dpt_pkg::dpt_look_t lookup(input logic [31:0] va);
    dpt_pkg::dpt_look_t r;
    dpt_pkg::dpt_entry_t e;
    dpt_pkg::dpt_paired_virtual_tag_t vpn;
    dpt_pkg::dpt_set_t set;
    logic odd;
    r = '0;
    vpn = va[31:dpt_pkg::PAIRED_VIRTUAL_TAG_LSB];
    set = va[19:dpt_pkg::PAIRED_VIRTUAL_TAG_LSB];
    for (int i = 0; i < dpt_pkg::VAR_N; i++) begin
      e = var_mem[i];
      odd = va[dpt_pkg::ODD_BIT];
      for (int j = 0; j < dpt_pkg::MASK_W; j++) begin
        if (e.mask[j]) begin
          odd = va[dpt_pkg::PAIRED_VIRTUAL_TAG_LSB + j];
        end
      end
      if (!e.hashed_entry_invalidate && ((e.paired_virtual_tag ^ vpn) & ~{3'h0, e.mask}) == '0) begin
        r.hit = 1'b1;
        r.idx = dpt_pkg::dpt_idx_t'(i);
        r.half = odd ? e.lo1 : e.lo0;
      end
    end
    for (int w = 0; w < dpt_pkg::WAYS; w++) begin
      e = fix_mem[{dpt_pkg::dpt_way_t'(w), set}];
      if (!e.hashed_entry_invalidate && e.paired_virtual_tag == vpn) begin
        r.hit = 1'b1;
        r.idx = dpt_pkg::dpt_idx_t'({dpt_pkg::dpt_way_t'(w), set})
          + dpt_pkg::FIX_BASE;
        r.half = va[dpt_pkg::ODD_BIT] ? e.lo1 : e.lo0;
      end
    end
    return r;
  endfunction
  function automatic logic [31:0] pack_lo(input dpt_pkg::dpt_half_t h);
    return {6'h00, h.pfn, 3'h0, h.d, h.v, 1'b0};
  endfunction
  function automatic dpt_pkg::dpt_half_t unpack_lo(input logic [31:0] d);
    dpt_pkg::dpt_half_t h;
    h.pfn = d[25:6];
    h.d = d[2];
    h.v = d[1];
    return h;
  endfunction

  // ==========================================================
  // Command decode and write target
  logic cmd_go;
  dpt_pkg::dpt_cmd_t cmd;
  dpt_pkg::dpt_look_t hlook;
  dpt_pkg::dpt_look_t tlook;
  dpt_pkg::dpt_idx_t wr_idx;
  dpt_pkg::dpt_faddr_t wr_faddr;
  dpt_pkg::dpt_faddr_t rd_faddr;
  dpt_pkg::dpt_entry_t new_entry;
  dpt_pkg::dpt_entry_t rd_entry;
  logic wr_en;
  logic wr_fix;
  logic set_bad;
  logic dup_hit;
  logic rd_ok;
  logic wired_we;
  assign cmd_go = bus_req.we && bus_req.addr == dpt_pkg::OFF_CMD;
  assign cmd = dpt_pkg::dpt_cmd_t'(bus_req.wdata[2:0]);
  // Arrays are read inside lookup, so a plain assign would miss writes
  always_comb begin
    hlook = lookup({hi_paired_virtual_tag_reg, 13'h0000});
    tlook = lookup(tr_req.va);
  end
  assign wired_we = bus_req.we && bus_req.addr == dpt_pkg::OFF_WIRED;
  always_comb begin
    wr_idx = index_reg[9:0];
    if (cmd == dpt_pkg::CMD_WRAND) begin
      if (pmask_reg == dpt_pkg::FIX_MASK) begin
        wr_idx = dpt_pkg::dpt_idx_t'({way_reg, hi_paired_virtual_tag_reg[6:0]})
          + dpt_pkg::FIX_BASE;
      end else begin
        wr_idx = dpt_pkg::dpt_idx_t'(random_reg);
      end
    end
  end
  assign wr_en = cmd_go && (cmd == dpt_pkg::CMD_WIDX ||
    cmd == dpt_pkg::CMD_WRAND) && wr_idx < dpt_pkg::IDX_LIMIT;
  assign wr_fix = wr_idx >= dpt_pkg::FIX_BASE;
  assign wr_faddr = dpt_pkg::dpt_faddr_t'(wr_idx - dpt_pkg::FIX_BASE);
  assign set_bad = wr_en && wr_fix
    && wr_faddr[6:0] != hi_paired_virtual_tag_reg[6:0];
  assign dup_hit = wr_en && !hi_hashed_entry_invalidate_reg && hlook.hit
    && hlook.idx != wr_idx;
  always_comb begin
    new_entry.paired_virtual_tag = hi_paired_virtual_tag_reg;
    new_entry.mask = wr_fix ? dpt_pkg::FIX_MASK : pmask_reg;
    new_entry.hashed_entry_invalidate = hi_hashed_entry_invalidate_reg;
    new_entry.lo0 = lo0_reg;
    new_entry.lo1 = lo1_reg;
  end
  assign rd_faddr = dpt_pkg::dpt_faddr_t'(index_reg[9:0]
    - dpt_pkg::FIX_BASE);
  assign rd_ok = cmd_go && cmd == dpt_pkg::CMD_READ
    && index_reg[9:0] < dpt_pkg::IDX_LIMIT;
  assign rd_entry = (index_reg[9:0] < dpt_pkg::FIX_BASE)
    ? var_mem[index_reg[2:0]] : fix_mem[rd_faddr];

  // ==========================================================
  // Entry arrays
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < dpt_pkg::VAR_N; i++) begin
        var_mem[i] <= '0;
        var_mem[i].hashed_entry_invalidate <= 1'b1;
      end
      for (int i = 0; i < dpt_pkg::FIX_N; i++) begin
        fix_mem[i] <= '0;
        fix_mem[i].hashed_entry_invalidate <= 1'b1;
      end
    end else if (wr_en && !set_bad) begin
      if (wr_fix) begin
        fix_mem[wr_faddr] <= new_entry;
      end else begin
        var_mem[wr_idx[2:0]] <= new_entry;
      end
    end
  end

  // ==========================================================
  // Entry interface registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hi_paired_virtual_tag_reg <= '0;
      hi_hashed_entry_invalidate_reg <= 1'b0;
      lo0_reg <= '0;
      lo1_reg <= '0;
    end else if (rd_ok) begin
      hi_paired_virtual_tag_reg <= rd_entry.paired_virtual_tag;
      hi_hashed_entry_invalidate_reg <= rd_entry.hashed_entry_invalidate;
      lo0_reg <= rd_entry.lo0;
      lo1_reg <= rd_entry.lo1;
    end else if (bus_req.we) begin
      if (bus_req.addr == dpt_pkg::OFF_HI) begin
        hi_paired_virtual_tag_reg <= bus_req.wdata[31:dpt_pkg::PAIRED_VIRTUAL_TAG_LSB];
        hi_hashed_entry_invalidate_reg <= bus_req.wdata[dpt_pkg::HI_HASHED_ENTRY_INVALIDATE_BIT];
      end
      if (bus_req.addr == dpt_pkg::OFF_LO0) begin
        lo0_reg <= unpack_lo(bus_req.wdata);
      end
      if (bus_req.addr == dpt_pkg::OFF_LO1) begin
        lo1_reg <= unpack_lo(bus_req.wdata);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pmask_reg <= '0;
    end else if (rd_ok) begin
      pmask_reg <= rd_entry.mask;
    end else if (cmd_go && cmd == dpt_pkg::CMD_PROBE && hlook.hit
        && hlook.idx >= dpt_pkg::FIX_BASE) begin
      pmask_reg <= dpt_pkg::FIX_MASK;
    end else if (bus_req.we && bus_req.addr == dpt_pkg::OFF_PMASK) begin
      pmask_reg <= bus_req.wdata[28:dpt_pkg::PAIRED_VIRTUAL_TAG_LSB];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      index_reg <= '0;
    end else if (cmd_go && cmd == dpt_pkg::CMD_PROBE) begin
      if (hlook.hit) begin
        index_reg <= {22'h00_0000, hlook.idx};
      end else begin
        index_reg <= 32'h8000_0000;
      end
    end else if (bus_req.we && bus_req.addr == dpt_pkg::OFF_INDEX) begin
      index_reg <= {22'h00_0000, bus_req.wdata[9:0]};
    end
  end

  // ==========================================================
  // Replacement state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wired_reg <= '0;
    end else if (wired_we) begin
      wired_reg <= bus_req.wdata[2:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst || wired_we || random_reg == wired_reg) begin
      random_reg <= dpt_pkg::RAND_RESET;
    end else begin
      random_reg <= random_reg - 3'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      way_reg <= '0;
    end else begin
      way_reg <= way_reg + 2'h1;
    end
  end

  // ==========================================================
  // Translation port
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tr_resp <= '0;
    end else begin
      tr_resp.hit <= tr_req.valid && tlook.hit;
      tr_resp.miss <= tr_req.valid && !tlook.hit;
      tr_resp.pfn <= tlook.half.pfn;
      tr_resp.v <= tlook.half.v;
      tr_resp.d <= tlook.half.d;
    end
  end

  // ==========================================================
  // Events and interrupt
  always_comb begin
    stat_next = stat_reg;
    if (bus_req.we && bus_req.addr == dpt_pkg::OFF_STAT) begin
      stat_next = stat_reg & ~bus_req.wdata[2:0];
    end
    stat_next[dpt_pkg::ST_MC_SET] = stat_next[dpt_pkg::ST_MC_SET]
      | set_bad;
    stat_next[dpt_pkg::ST_MC_DUP] = stat_next[dpt_pkg::ST_MC_DUP]
      | dup_hit;
    stat_next[dpt_pkg::ST_MISS] = stat_next[dpt_pkg::ST_MISS]
      | (tr_req.valid && !tlook.hit);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_reg <= '0;
      imask_reg <= '0;
    end else begin
      stat_reg <= stat_next;
      if (bus_req.we && bus_req.addr == dpt_pkg::OFF_IMASK) begin
        imask_reg <= bus_req.wdata[2:0];
      end
    end
  end

  assign irq = |(stat_reg & imask_reg);

  // ==========================================================
  // Read data
  always_ff @(posedge clk_sys) begin
    if (rst || !bus_req.re) begin
      bus_rdata <= '0;
    end else begin
      case (bus_req.addr)
        dpt_pkg::OFF_INDEX: bus_rdata <= index_reg;
        dpt_pkg::OFF_RANDOM: bus_rdata <= {29'h0000_0000, random_reg};
        dpt_pkg::OFF_LO0: bus_rdata <= pack_lo(lo0_reg);
        dpt_pkg::OFF_LO1: bus_rdata <= pack_lo(lo1_reg);
        dpt_pkg::OFF_PMASK: bus_rdata <= {3'h0, pmask_reg, 13'h0000};
        dpt_pkg::OFF_WIRED: bus_rdata <= {29'h0000_0000, wired_reg};
        dpt_pkg::OFF_HI: bus_rdata <= {hi_paired_virtual_tag_reg, 2'h0, hi_hashed_entry_invalidate_reg,
          10'h000};
        dpt_pkg::OFF_CONFIG: bus_rdata <= {22'h00_0000, dpt_pkg::MT_DUAL,
          7'h00};
        dpt_pkg::OFF_CONFIG1: bus_rdata <= {1'b0, dpt_pkg::VAR_SIZE_M1,
          25'h000_0000};
        dpt_pkg::OFF_CONFIG_REG_FOUR: bus_rdata <= {16'h0000, dpt_pkg::EXT_DEF,
          2'h0, dpt_pkg::CFG4_SETS_LOG2, dpt_pkg::CFG4_WAYS_LOG2,
          dpt_pkg::CFG4_PAGE_LOG2};
        dpt_pkg::OFF_STAT: bus_rdata <= {29'h0000_0000, stat_reg};
        dpt_pkg::OFF_IMASK: bus_rdata <= {29'h0000_0000, imask_reg};
        default: bus_rdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence probe_cmd_s;
    cmd_go && cmd == dpt_pkg::CMD_PROBE;
  endsequence
  sequence rand_var_s;
    cmd_go && cmd == dpt_pkg::CMD_WRAND
      && pmask_reg != dpt_pkg::FIX_MASK;
  endsequence
  probe_index_a: assert property (probe_cmd_s and hlook.hit |=>
    index_reg[9:0] == $past(hlook.idx) && !index_reg[31])
    else $error("probe hit index wrong");
  probe_fail_a: assert property (probe_cmd_s and !hlook.hit |=>
    index_reg[dpt_pkg::IDX_FAIL_BIT])
    else $error("probe miss not flagged");
  tr_miss_a: assert property (tr_req.valid && !tlook.hit |=>
    tr_resp.miss && !tr_resp.hit)
    else $error("translation miss not signalled");
  tr_hit_a: assert property (tr_req.valid && tlook.hit |=>
    tr_resp.hit && tr_resp.pfn == $past(tlook.half.pfn))
    else $error("translation frame wrong");
  rand_wrap_a: assert property (!wired_we && random_reg == wired_reg
    |=> random_reg == dpt_pkg::RAND_RESET)
    else $error("random index did not wrap");
  rand_var_a: assert property (rand_var_s |=>
    var_mem[$past(random_reg)].paired_virtual_tag == $past(hi_paired_virtual_tag_reg))
    else $error("random write missed variable entry");
  set_check_a: assert property (set_bad |=>
    stat_reg[dpt_pkg::ST_MC_SET])
    else $error("unsuitable set not flagged");
  way_count_a: assert property (1'b1 |=>
    way_reg == dpt_pkg::dpt_way_t'($past(way_reg) + 2'h1))
    else $error("way counter stalled");
  cfg_type_a: assert property (bus_req.re
    && bus_req.addr == dpt_pkg::OFF_CONFIG |=> bus_rdata[9:7] == 3'h4)
    else $error("mmu type field wrong");
  fix_mask_a: assert property (wr_en && wr_fix && !set_bad |=>
    fix_mem[$past(wr_faddr)].mask == dpt_pkg::FIX_MASK)
    else $error("fixed entry took other page size");
endmodule

// file: dv/dpt_pipe_model.sv
`timescale 1ns/1ps
// ====================
// Pipeline side: register master and translation requester
module dpt_pipe_model (
  input wire logic clk_sys,
  output dpt_pkg::dpt_bus_req_t bus_req,
  output dpt_pkg::dpt_tr_req_t tr_req
);
  initial begin
    bus_req = '0;
    tr_req = '0;
  end

  // One request per edge; va and wdata both carry d, any other unused field carries inverted junk
  task automatic drive(input logic [7:0] a, input logic [31:0] d,
                       input logic [2:0] op);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.we <= op[0];
    bus_req.re <= op[1];
    tr_req.valid <= op[2];
    tr_req.va <= d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    drive(a, d, 3'b001);
  endtask

  task automatic rd(input logic [7:0] a);
    drive(a, ~bus_req.wdata, 3'b010);
  endtask

  // Fixed page size is never reconfigured from this side
  task automatic xl(input logic [31:0] va);
    drive(~bus_req.addr, va, 3'b100);
  endtask

  task automatic idle();
    drive(~bus_req.addr, ~bus_req.wdata, 3'b000);
  endtask
endmodule

// file: dv/dpt_dual_tlb_tb_top.sv
`timescale 1ns/1ps
module dpt_dual_tlb_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  dpt_pkg::dpt_bus_req_t bus_req;
  dpt_pkg::dpt_tr_req_t tr_req;
  dpt_pkg::dpt_tr_resp_t tr_resp;
  dpt_pkg::dpt_tr_resp_t te;
  dpt_pkg::dpt_tr_resp_t tq[$];
  logic [32:0] rq[$];
  logic [32:0] rn;
  logic [31:0] bus_rdata;
  logic [31:0] v;
  logic irq;
  logic re_d = 1'b0;
  logic [18:0] ta, tb, tc, td;
  logic [19:0] p0, p1;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 32'h02a8_4bc0;

  always #2.5 clk_sys = ~clk_sys;

  dpt_dual_tlb u_dpt_dual_tlb (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .tr_req(tr_req),
    .tr_resp(tr_resp),
    .irq(irq)
  );

  dpt_pipe_model pipe (
    .clk_sys(clk_sys),
    .bus_req(bus_req),
    .tr_req(tr_req)
  );

  // ====================
  // Checking helpers
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk_sys) re_d <= bus_req.re;

  // Oldest note against each result as it appears
  always @(negedge clk_sys) begin
    if (re_d === 1'b1 && rq.size() > 0) begin
      rn = rq.pop_front();
      if (rn[32]) chk("rdata", bus_rdata, rn[31:0]);
    end
    if ((tr_resp.hit | tr_resp.miss) === 1'b1) begin
      te = '0;
      if (tq.size() > 0) te = tq.pop_front();
      if (te.miss) begin
        chk("tr_hm", {30'h0, tr_resp.hit, tr_resp.miss},
            {30'h0, te.hit, te.miss});
      end else begin
        chk("tr", {8'h00, tr_resp}, {8'h00, te});
      end
    end
  end

  // ====================
  // Stimulus tasks
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    rq.push_back({1'b1, e});
    pipe.rd(a);
  endtask

  task automatic peek(input logic [7:0] a);
    rq.push_back({1'b0, 32'h0000_0000});
    pipe.rd(a);
    pipe.idle();
    #1 v = bus_rdata;
  endtask

  task automatic xp(input logic [31:0] va, input logic h,
                    input logic [19:0] p);
    tq.push_back({h, ~h, p, h, h});
    pipe.xl(va);
  endtask

  task automatic irqx(input logic e);
    pipe.idle();
    #1 chk("irq", {31'h0, irq}, {31'h0, e});
  endtask

  task automatic cmd(input dpt_pkg::dpt_cmd_t c);
    pipe.wr(dpt_pkg::OFF_CMD, {29'h0, c});
    pipe.idle();
  endtask

  task automatic ent(input logic [31:0] ix, input logic [18:0] t,
                     input logic [15:0] m, input dpt_pkg::dpt_cmd_t c);
    p0 = 20'($random(seed));
    p1 = 20'($random(seed));
    pipe.wr(dpt_pkg::OFF_INDEX, ix);
    pipe.wr(dpt_pkg::OFF_HI, {t, 13'h0000});
    pipe.wr(dpt_pkg::OFF_LO0, {6'h00, p0, 6'h06});
    pipe.wr(dpt_pkg::OFF_LO1, {6'h00, p1, 6'h06});
    pipe.wr(dpt_pkg::OFF_PMASK, {3'h0, m, 13'h0000});
    cmd(c);
  endtask

  // ====================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    ta = {2'b00, 17'($random(seed))};
    tb = {2'b01, 10'($random(seed)), 7'h7F};
    tc = {2'b10, 17'($random(seed))};
    td = ta ^ 19'h0_1000;
    rdx(dpt_pkg::OFF_CONFIG, 32'h0000_0200);
    rdx(dpt_pkg::OFF_CONFIG1, 32'h0E00_0000);
    rdx(dpt_pkg::OFF_CONFIG_REG_FOUR, 32'h0000_872C);
    rdx(8'h3C, 32'h0000_0000);
    rdx(dpt_pkg::OFF_INDEX, 32'h0000_0000);
    xp({ta, 13'h0000}, 1'b0, 20'h0_0000);
    pipe.idle();
    rdx(dpt_pkg::OFF_STAT, 32'h0000_0004);
    irqx(1'b0);
    pipe.wr(dpt_pkg::OFF_IMASK, 32'h0000_0004);
    irqx(1'b1);
    pipe.wr(dpt_pkg::OFF_STAT, 32'h0000_0004);
    irqx(1'b0);
    // Variable entry 3, both halves
    ent(32'h0000_0003, ta, 16'h0000, dpt_pkg::CMD_WIDX);
    xp({ta, 13'h0000}, 1'b1, p0);
    xp({ta, 13'h1000}, 1'b1, p1);
    cmd(dpt_pkg::CMD_PROBE);
    rdx(dpt_pkg::OFF_INDEX, 32'h0000_0003);
    // Last fixed slot: way 3, set 7F
    ent(32'h0000_0207, tb, 16'h0000, dpt_pkg::CMD_WIDX);
    pipe.wr(dpt_pkg::OFF_PMASK, 32'h0000_6000);
    cmd(dpt_pkg::CMD_PROBE);
    rdx(dpt_pkg::OFF_INDEX, 32'h0000_0207);
    rdx(dpt_pkg::OFF_PMASK, 32'h0000_0000);
    xp({tb, 13'h1000}, 1'b1, p1);
    pipe.wr(dpt_pkg::OFF_HI, 32'h0000_0000);
    cmd(dpt_pkg::CMD_READ);
    rdx(dpt_pkg::OFF_HI, {tb, 13'h0000});
    rdx(dpt_pkg::OFF_LO1, {6'h00, p1, 6'h06});
    // Tag placed in the wrong set
    ent(32'h0000_0008, tb ^ 19'h0_0100, 16'h0000, dpt_pkg::CMD_WIDX);
    rdx(dpt_pkg::OFF_STAT, 32'h0000_0001);
    irqx(1'b0);
    pipe.wr(dpt_pkg::OFF_IMASK, 32'h0000_0007);
    irqx(1'b1);
    xp({tb ^ 19'h0_0100, 13'h0000}, 1'b0, 20'h0_0000);
    cmd(dpt_pkg::CMD_PROBE);
    rdx(dpt_pkg::OFF_INDEX, 32'h8000_0000);
    pipe.wr(dpt_pkg::OFF_STAT, 32'h0000_0007);
    irqx(1'b0);
    // Duplicate tag in another slot
    ent(32'h0000_0000, ta, 16'h0000, dpt_pkg::CMD_WIDX);
    rdx(dpt_pkg::OFF_STAT, 32'h0000_0002);
    pipe.wr(dpt_pkg::OFF_STAT, 32'h0000_0002);
    // Random write at fixed page size
    ent(32'h0000_0000, tc, 16'h0000, dpt_pkg::CMD_WRAND);
    xp({tc, 13'h0000}, 1'b1, p0);
    cmd(dpt_pkg::CMD_PROBE);
    peek(dpt_pkg::OFF_INDEX);
    chk("rand_set", {25'h0, 7'(v - 32'h0000_0008)}, {25'h0, tc[6:0]});
    chk("rand_idx", {31'h0, v >= 32'h0000_0008 && v < 32'h0000_0208},
        32'h0000_0001);
    // Random write at another page size
    pipe.wr(dpt_pkg::OFF_WIRED, 32'h0000_000F);
    rdx(dpt_pkg::OFF_WIRED, 32'h0000_0007);
    rdx(dpt_pkg::OFF_RANDOM, 32'h0000_0007);
    ent(32'h0000_0000, td, 16'h0003, dpt_pkg::CMD_WRAND);
    cmd(dpt_pkg::CMD_PROBE);
    rdx(dpt_pkg::OFF_INDEX, 32'h0000_0007);
    xp({td[18:2], 2'b01, 13'h0000}, 1'b1, p0);
    xp({td[18:2], 2'b10, 13'h0000}, 1'b1, p1);
    for (int i = 0; i < 8; i++) begin
      xp({2'b11, 30'($random(seed))}, 1'b0, 20'h0_0000);
    end
    pipe.idle();
    rdx(dpt_pkg::OFF_STAT, 32'h0000_0004);
    irqx(1'b1);
    repeat (3) pipe.idle();
    chk("pending", 32'(rq.size() + tq.size()), 32'h0000_0000);
    final_report();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    final_report();
  end
endmodule
